// ### flash_map_regs.vh
// constants for the flash address map and protection decode
`ifndef FLASH_MAP_REGS_VH
`define FLASH_MAP_REGS_VH
`define FLASH_LOW_START     16'h4000
`define FLASH_HIGH_END      16'hffff
`define WIN_MID_START       16'h8000
`define WIN_MID_END         16'hbfff
`define WIN_TOP_START       16'hc000
`define PAGE_FIXED_LOW      8'h3e
`define PAGE_FIXED_TOP      8'h3f
`define PAGE_BLOCK1_FIRST   8'h30
`define PAGE_BLOCK0_FIRST   8'h38
`define PAGE_FLASH_HI_NIB   4'h3
`define PAGE_NEXT_TO_LAST   3'h6
`define PAGE_LAST           3'h7
`define PAGE_SPAN           15'h4000
`define LOWER_UNIT          15'h0400
`define HIGHER_UNIT         15'h0800
`define PROT_OPEN_BIT       7
`define PROT_REST_BIT       6
`define PROT_HIGH_BIT       5
`define PROT_HSIZE_MSB      4
`define PROT_HSIZE_LSB      3
`define PROT_LOW_BIT        2
`define PROT_LSIZE_MSB      1
`define PROT_LSIZE_LSB      0
`define CFG_BASE            17'h1ff00
`define CFG_ROW             13'h1ff0
`define CFG_KEY_LAST        4'h7
`define CFG_RSV_LAST        4'hb
`define CFG_PROT_BLOCK1     4'hc
`define CFG_PROT_BLOCK0     4'hd
`define CFG_OPTION          4'he
`define CFG_SECURITY        4'hf
`define FIELD_NONE          3'h0
`define FIELD_KEY           3'h1
`define FIELD_RSV           3'h2
`define FIELD_PROT1         3'h3
`define FIELD_PROT0         3'h4
`define FIELD_OPTION        3'h5
`define FIELD_SECURITY      3'h6
`define REG_BANKED_FIRST    4'h4
`define REG_BANKED_LAST     4'hb
`define SECTOR_MSB          16
`define SECTOR_LSB          10
`endif

// ### flash_address_map_protect.v
// address map, protection region and register bank decode for the flash
`timescale 1ns/10ps
`include "flash_map_regs.vh"
module flash_address_map_protect (
  input  wire        clock,
  input  wire        rstn,
  input  wire        accessValid,
  input  wire [15:0] cpuAddr,
  input  wire [7:0]  pageSelect,
  input  wire [7:0]  protectBlock0,
  input  wire [7:0]  protectBlock1,
  input  wire        regAccess,
  input  wire [3:0]  regOffset,
  input  wire        bankSelectBit,
  output reg         flashHit_reg,
  output reg         blockSel_reg,
  output reg  [16:0] blockAddr_reg,
  output reg  [6:0]  sectorIndex_reg,
  output reg         inLower_reg,
  output reg         inHigher_reg,
  output reg         inRest_reg,
  output reg         writeAllowed_reg,
  output reg  [2:0]  cfgField_reg,
  output reg         regBanked_reg,
  output reg         regBank_reg,
  output reg         regCommon_reg
);

  // effective physical page for a logical address; bit 8 flags a miss
  function [8:0] effPage;
    input [15:0] a;
    input [7:0]  p;
    begin
      if (a < `FLASH_LOW_START)
        effPage = 9'h100;
      else if (a < `WIN_MID_START)
        effPage = {1'b0, `PAGE_FIXED_LOW};
      else if (a <= `WIN_MID_END) begin
        if (p[7:4] == `PAGE_FLASH_HI_NIB)
          effPage = {1'b0, p};
        else
          effPage = 9'h100;
      end else
        effPage = {1'b0, `PAGE_FIXED_TOP};
    end
  endfunction

  // region size in bytes for a 2-bit size code
  function [14:0] regionBytes;
    input [14:0] unit;
    input [1:0]  code;
    begin
      regionBytes = unit << code;
    end
  endfunction

  reg  [8:0]  page;
  reg         hit;
  reg         blk;
  reg  [16:0] bAddr;
  reg  [7:0]  prot;
  reg  [14:0] offs;
  reg         lower;
  reg         higher;
  reg         rest;
  reg         protectedHit;
  reg  [2:0]  field;
  reg         banked;

  always @* begin
    page = effPage(cpuAddr, pageSelect);
    hit = accessValid && !page[8] && (cpuAddr >= `FLASH_LOW_START);
    // block 1 for pages below 0x38, block 0 from 0x38 upward
    blk = (page[7:0] < `PAGE_BLOCK0_FIRST);
    bAddr = {page[2:0], cpuAddr[13:0]};
    prot = blk ? protectBlock1 : protectBlock0;
    offs = {1'b0, cpuAddr[13:0]};
    lower = (bAddr[16:14] == `PAGE_NEXT_TO_LAST) &&
            (offs < regionBytes(`LOWER_UNIT,
                                prot[`PROT_LSIZE_MSB:`PROT_LSIZE_LSB]));
    higher = (bAddr[16:14] == `PAGE_LAST) &&
             (offs >= (`PAGE_SPAN - regionBytes(`HIGHER_UNIT,
                       prot[`PROT_HSIZE_MSB:`PROT_HSIZE_LSB])));
    rest = !lower && !higher;
    // open bit low locks the whole block, regions ignored
    if (!prot[`PROT_OPEN_BIT])
      protectedHit = 1'b1;
    else if (lower)
      protectedHit = prot[`PROT_LOW_BIT];
    else if (higher)
      protectedHit = prot[`PROT_HIGH_BIT];
    else
      protectedHit = prot[`PROT_REST_BIT];
    field = `FIELD_NONE;
    // a literal cannot be part-selected, so the row has its own constant
    if (hit && !blk && (bAddr[16:4] == `CFG_ROW)) begin
      if (bAddr[3:0] <= `CFG_KEY_LAST)
        field = `FIELD_KEY;
      else if (bAddr[3:0] <= `CFG_RSV_LAST)
        field = `FIELD_RSV;
      else if (bAddr[3:0] == `CFG_PROT_BLOCK1)
        field = `FIELD_PROT1;
      else if (bAddr[3:0] == `CFG_PROT_BLOCK0)
        field = `FIELD_PROT0;
      else if (bAddr[3:0] == `CFG_OPTION)
        field = `FIELD_OPTION;
      else
        field = `FIELD_SECURITY;
    end
    banked = (regOffset >= `REG_BANKED_FIRST) &&
             (regOffset <= `REG_BANKED_LAST);
  end

  // outputs registered, so decode lands one clock after the request
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flashHit_reg     <= 1'b0;
      blockSel_reg     <= 1'b0;
      blockAddr_reg    <= 17'h00000;
      sectorIndex_reg  <= 7'h00;
      inLower_reg      <= 1'b0;
      inHigher_reg     <= 1'b0;
      inRest_reg       <= 1'b0;
      writeAllowed_reg <= 1'b0;
      cfgField_reg     <= `FIELD_NONE;
      regBanked_reg    <= 1'b0;
      regBank_reg      <= 1'b0;
      regCommon_reg    <= 1'b0;
    end else begin
      flashHit_reg     <= hit;
      // misses clear the detail outputs so stale data never looks valid
      blockSel_reg     <= hit & blk;
      blockAddr_reg    <= hit ? bAddr : 17'h00000;
      sectorIndex_reg  <= hit ? bAddr[`SECTOR_MSB:`SECTOR_LSB] : 7'h00;
      inLower_reg      <= hit & lower;
      inHigher_reg     <= hit & higher;
      inRest_reg       <= hit & rest;
      writeAllowed_reg <= hit & !protectedHit;
      cfgField_reg     <= field;
      regBanked_reg    <= regAccess & banked;
      regBank_reg      <= regAccess & banked & bankSelectBit;
      regCommon_reg    <= regAccess & !banked;
    end
  end

endmodule

// ### flash_map_props.sv
// assertions on the flash map decode ports
`timescale 1ns/10ps
module flash_map_props (
  input wire logic        clock, rstn, accessValid, regAccess, bankSelectBit,
  input wire logic [15:0] cpuAddr,
  input wire logic [7:0]  pageSelect, protectBlock0,
  input wire logic [3:0]  regOffset,
  input wire logic        flashHit_reg, blockSel_reg, writeAllowed_reg,
  input wire logic        regBanked_reg, regBank_reg, regCommon_reg,
  input wire logic [16:0] blockAddr_reg,
  input wire logic [2:0]  cfgField_reg
);
  wire banked = regOffset >= 4'h4 && regOffset <= 4'hb;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  miss_low_a: assert property (accessValid && cpuAddr < 16'h4000
    |=> !flashHit_reg) else $error("hit below flash");
  top_fixed_a: assert property (accessValid && cpuAddr[15:14] == 2'h3
    |=> blockAddr_reg == {3'h7, $past(cpuAddr[13:0])}) else $error("top");
  low_fixed_a: assert property (accessValid && cpuAddr[15:14] == 2'h1
    |=> blockAddr_reg == {3'h6, $past(cpuAddr[13:0])}) else $error("low");
  paged_blk_a: assert property (accessValid && cpuAddr[15:14] == 2'h2
    && pageSelect[7:4] == 4'h3 |=> blockSel_reg == !$past(pageSelect[3]))
    else $error("block");
  whole_prot_a: assert property (accessValid && !protectBlock0[7]
    && cpuAddr[15:14] == 2'h3 |=> !writeAllowed_reg) else $error("prot");
  cfg_key_a: assert property (accessValid && cpuAddr[15:3] == 13'h1fe0
    |=> cfgField_reg == 3'h1) else $error("key");
  bank_route_a: assert property (regAccess && banked
    |=> regBanked_reg && regBank_reg == $past(bankSelectBit))
    else $error("bank");
  common_reg_a: assert property (regAccess && !banked
    |=> regCommon_reg && !regBank_reg) else $error("common");
endmodule
bind flash_address_map_protect flash_map_props props (.*);

// ### cpu_bus_model.sv
// cpu core bus model issuing flash requests
`timescale 1ns/10ps
module cpu_bus_model (
  input wire logic         clock,
  output logic             accessValid = 1'h0,
  output logic [15:0]      cpuAddr = 16'h0000,
  output logic [7:0]       pageSelect = 8'h00
);
  // one request per two edges; released cpuAddr shows the inverse, pageSelect keeps its last value
  // reads only: no command write sequence is ever issued here
  task automatic issue(input logic [15:0] a, input logic [7:0] p);
    @(posedge clock) #1;
    accessValid = 1'h1;
    cpuAddr = a;
    pageSelect = p;
    @(posedge clock) #1;
    accessValid = 1'h0;
    cpuAddr = ~a;
  endtask
endmodule

// ### tb_flash_address_map_protect.sv
// bench for the flash map decode
`timescale 1ns/10ps
module tb_flash_address_map_protect;
  logic clock, rstn, accessValid, regAccess, bankSelectBit;
  logic [15:0] cpuAddr;
  logic [7:0] pageSelect, protectBlock0, protectBlock1, p;
  logic [3:0] regOffset;
  logic flashHit_reg, blockSel_reg, inLower_reg, inHigher_reg, inRest_reg;
  logic writeAllowed_reg, regBanked_reg, regBank_reg, regCommon_reg, b;
  logic [16:0] blockAddr_reg;
  logic [6:0] sectorIndex_reg;
  logic [2:0] cfgField_reg, f;
  logic [15:0] e;
  int num_errors = 0;
  int total_checks = 0;
  flash_address_map_protect dut (.*);
  cpu_bus_model cpu (.*);
  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_map;
    for (int i = 0; i < 16; i++) begin
      p = 8'h30 + i[7:0];
      cpu.issue(16'h8523, p);
      check({blockSel_reg, blockAddr_reg}, {p < 8'h38, p[2:0], 14'h0523});
      check(sectorIndex_reg, {p[2:0], 4'h1});
    end
    cpu.issue(16'h4000, 8'h00);
    check({flashHit_reg, blockAddr_reg}, 18'h38000);
    cpu.issue(16'h3fff, 8'h3f);
    check(flashHit_reg, 1'h0);
    cpu.issue(16'h8000, 8'h20);
    check({flashHit_reg, blockAddr_reg}, 18'h00000);
    $display("t_map done");
  endtask
  task automatic t_prot;
    for (int n = 0; n < 4; n++) begin
      protectBlock0 = 8'h84 | n[7:0];
      e = 16'h4000 + (16'h0400 << n);
      cpu.issue(e - 16'h1, 8'h00);
      check({inLower_reg, inRest_reg, writeAllowed_reg}, 3'h4);
      cpu.issue(e, 8'h00);
      check({inLower_reg, inRest_reg, writeAllowed_reg}, 3'h3);
      protectBlock0 = 8'ha0 | (n[7:0] << 3);
      e = 16'h0000 - (16'h0800 << n);
      cpu.issue(e, 8'h00);
      check({inHigher_reg, inRest_reg, writeAllowed_reg}, 3'h4);
      cpu.issue(e - 16'h1, 8'h3e);
      check({inHigher_reg, inRest_reg, writeAllowed_reg}, 3'h3);
    end
    protectBlock0 = 8'hc3;
    cpu.issue(16'h5fff, 8'h00);
    check(writeAllowed_reg, 1'h1);
    cpu.issue(16'h6000, 8'h00);
    check(writeAllowed_reg, 1'h0);
    protectBlock1 = 8'h00;
    cpu.issue(16'h8000, 8'h36);
    check({blockSel_reg, writeAllowed_reg}, 2'h2);
    $display("t_prot done");
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 17; i++) begin
      f = i < 8 ? 3'h1 : i < 12 ? 3'h2 : i < 16 ? 3'(i - 9) : 3'h0;
      cpu.issue(16'hff00 + i[15:0], 8'h00);
      check(cfgField_reg, f);
      cpu.issue(16'hbf00 + i[15:0], 8'h3f);
      check(cfgField_reg, f);
    end
    $display("t_cfg done");
  endtask
  task automatic t_reg;
    for (int i = 0; i < 32; i++) begin
      @(posedge clock) #1;
      regAccess = 1'h1;
      regOffset = i[3:0];
      bankSelectBit = i[4];
      @(posedge clock) #1;
      regAccess = 1'h0;
      b = i[3:0] >= 4'h4 && i[3:0] <= 4'hb;
      check({regBanked_reg, regBank_reg, regCommon_reg}, {b, b & i[4], !b});
    end
    $display("t_reg done");
  endtask
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  initial begin
    {rstn, regAccess, regOffset, bankSelectBit} = 7'h00;
    protectBlock0 = 8'h80;
    protectBlock1 = 8'h80;
    repeat (20) @(posedge clock);
    #1 rstn = 1'h1;
    t_map();
    t_prot();
    t_cfg();
    t_reg();
    stop_test();
  end
endmodule
